//--- rtl/sfr_pkg.sv
// Shared constants, types and the command plan table of the multi-lane flash read path.
// Assumes a mode-0 serial link, MSB first, and a single flash die behind it.
// Behaviour
// - Fast read: opcode, address, dummy byte, rising-edge sampling
// - Fast read data leaves on falling edges
// - Address increments per byte, wraps to zero
// - Chip select high ends read, output stops
// - Fast read rejected while write busy
// - Dual output: single-lane address, eight dummies, two lanes
// - Host releases lanes before first data edge
// - Dual I/O: address two bits per clock
// - Dual mode bits 10 skip next opcode
// - Other dual mode bits need full opcode
// - Mode reset command clears continuous mode bits
// - Quad output: single-lane address, eight dummies, four lanes
// - Quad reads need quad lane enable set; checked at the opcode only, so continuous-mode quad frames skip the check
// - Quad I/O: four lanes after opcode, mode byte, four dummies
// - Quad continuous: mode byte, four dummies, address only
// - Quad mode bits 10 keep continuous mode
// - Quad I/O read rejected while write busy
// - I/O reads also increment and wrap address
// - Lane 3 carries most significant nibble bit
package sfr_pkg;

  // ==========================================================
  // Opcodes
  localparam logic [7:0] OP_FAST  = 8'h0B;
  localparam logic [7:0] OP_DOUT  = 8'h3B;
  localparam logic [7:0] OP_DIO   = 8'hBB;
  localparam logic [7:0] OP_QOUT  = 8'h6B;
  localparam logic [7:0] OP_QIO   = 8'hEB;
  localparam logic [7:0] OP_MRST  = 8'hFF;

  // ==========================================================
  // Counts and reset values
  localparam int          CMD_CLKS  = 8;
  localparam int          ADDR_BITS = 24;
  localparam int          BYTE_BITS = 8;
  localparam int          DUMMY_STD = 8;
  localparam int          DUMMY_QIO = 4;
  localparam int          SCLK_HALF = 8;
  localparam logic [1:0]  MODE_KEEP = 2'h2;
  localparam logic [23:0] ADDR_RST  = 24'h000000;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {K_NONE, K_FAST, K_DOUT, K_DIO, K_QOUT, K_QIO, K_MRST} sfr_kind_e;
  typedef enum logic [2:0] {PH_IDLE, PH_CMD, PH_ADDR, PH_MODE, PH_DUMMY, PH_DATA} sfr_ph_e;

  // Lane widths are log2 of the lane count
  typedef struct packed {
    logic [1:0] al;
    logic [1:0] dl;
    logic [4:0] ac;
    logic [3:0] mc;
    logic [3:0] dm;
    logic [3:0] bc;
    logic       q;
  } sfr_plan_s;

  function automatic sfr_plan_s sfr_plan(input sfr_kind_e k);
    sfr_plan_s p;
    p = '0;
    case (k)
      K_FAST: p.dm = 4'(DUMMY_STD);
      K_DOUT: begin
        p.dl = 2'h1;
        p.dm = 4'(DUMMY_STD);
      end
      K_DIO: begin
        p.al = 2'h1;
        p.dl = 2'h1;
        p.mc = 4'(BYTE_BITS >> 1);
      end
      K_QOUT: begin
        p.dl = 2'h2;
        p.dm = 4'(DUMMY_STD);
        p.q  = 1'b1;
      end
      K_QIO: begin
        p.al = 2'h2;
        p.dl = 2'h2;
        p.mc = 4'(BYTE_BITS >> 2);
        p.dm = 4'(DUMMY_QIO);
        p.q  = 1'b1;
      end
      K_MRST: p.al = 2'h2;
      default: p.al = 2'h0;
    endcase
    p.ac = 5'(ADDR_BITS >> p.al);
    p.bc = 4'(BYTE_BITS >> p.dl);
    return p;
  endfunction

  function automatic sfr_kind_e sfr_kind(input logic [7:0] op);
    case (op)
      OP_FAST: return K_FAST;
      OP_DOUT: return K_DOUT;
      OP_DIO:  return K_DIO;
      OP_QOUT: return K_QOUT;
      OP_QIO:  return K_QIO;
      OP_MRST: return K_MRST;
      default: return K_NONE;
    endcase
  endfunction

  function automatic logic [7:0] sfr_op(input sfr_kind_e k);
    case (k)
      K_FAST:  return OP_FAST;
      K_DOUT:  return OP_DOUT;
      K_DIO:   return OP_DIO;
      K_QOUT:  return OP_QOUT;
      K_QIO:   return OP_QIO;
      default: return OP_MRST;
    endcase
  endfunction

endpackage

//--- rtl/sfr_if.sv
// Serial link between flash read engine and its host.
// Assumes unselected lanes float high through a pull-up.
interface sfr_if;
  logic       sclk;
  logic       cs_n;
  logic [3:0] h_o;
  logic [3:0] h_oe;
  logic [3:0] d_o;
  logic [3:0] d_oe;
  logic [3:0] io;

  // Wire level from both sets of enables
  assign io = (d_oe & d_o) | (h_oe & ~d_oe & h_o) | ~(d_oe | h_oe);

  modport dev (input sclk, input cs_n, input io, output d_o, output d_oe);
  modport host (output sclk, output cs_n, output h_o, output h_oe, input io);
endinterface

//--- rtl/sfr_sync.sv
// Three-stage synchroniser with agreement filter.
// Assumes the input is a level from another clock domain.
module sfr_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  always_comb begin
    q_nxt = (s2_r == s3_r) ? s3_r : q_r;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r  <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= q_nxt;
    end
  end

  assign q = q_r;

endmodule

//--- rtl/sfr_dev.sv
// Flash side of the multi-lane read path: command decode, address capture,
// continuous-read mode and lane drive, all on the link clock.
// Assumes the array answers mem_rdata combinationally from mem_addr.
module sfr_dev (
  // Link
  sfr_if.dev               lnk,
  // Reset and status
  input  wire logic        nrst,
  input  wire logic        quad_lane_enable,
  input  wire logic        write_busy_flag,
  // Array
  output logic      [23:0] mem_addr,
  input  wire logic [7:0]  mem_rdata,
  // State
  output logic             cont_active
);

  // ==========================================================
  // Declarations
  sfr_pkg::sfr_ph_e   ph_r;
  sfr_pkg::sfr_ph_e   ph_nxt;
  sfr_pkg::sfr_ph_e   ph_e;
  sfr_pkg::sfr_plan_s pl_r;
  sfr_pkg::sfr_plan_s pl_nxt;
  sfr_pkg::sfr_plan_s pl_e;
  sfr_pkg::sfr_kind_e cont_r;
  sfr_pkg::sfr_kind_e cont_nxt;
  sfr_pkg::sfr_kind_e kd_r;
  sfr_pkg::sfr_kind_e kd_nxt;
  sfr_pkg::sfr_kind_e kd_e;
  sfr_pkg::sfr_kind_e k;
  logic [4:0]         cnt_r;
  logic [4:0]         cnt_nxt;
  logic [4:0]         cnt_e;
  logic [23:0]        sh_r;
  logic [23:0]        sh_nxt;
  logic [23:0]        sh_in;
  logic [23:0]        addr_r;
  logic [23:0]        addr_nxt;
  logic               fst_r;
  logic               xip_r;
  logic               xip_nxt;
  logic [1:0]         lw;
  logic               qe_s;
  logic               busy_s;
  logic [3:0]         o_r;
  logic [3:0]         o_nxt;
  logic [3:0]         oe_r;
  logic [3:0]         oe_nxt;
  logic [7:0]         hold_r;
  logic [7:0]         hold_nxt;
  logic [7:0]         src;

  // ==========================================================
  // Status bits from the system domain
  sfr_sync #(
    .W (2)
  ) u_sync (
    .clk  (lnk.sclk),
    .nrst (nrst),
    .d    ({quad_lane_enable, write_busy_flag}),
    .q    ({qe_s, busy_s})
  );

  // ==========================================================
  // Rising edge: sampling and sequencing
  always_comb begin
    ph_e    = ph_r;
    pl_e    = pl_r;
    cnt_e   = cnt_r;
    kd_e    = kd_r;
    xip_nxt = xip_r;
    // A frame in continuous mode starts straight at the address
    if (fst_r && cont_r != sfr_pkg::K_NONE) begin
      pl_e    = sfr_pkg::sfr_plan(cont_r);
      ph_e    = sfr_pkg::PH_ADDR;
      cnt_e   = pl_e.ac;
      kd_e    = cont_r;
      xip_nxt = 1'b1;
    end else if (fst_r) begin
      cnt_e = 5'(sfr_pkg::CMD_CLKS);
    end
    if (ph_e == sfr_pkg::PH_CMD) begin
      lw = 2'h0;
    end else begin
      lw = pl_e.al;
    end
    case (lw)
      2'h1:    sh_in = {sh_r[21:0], lnk.io[1:0]};
      2'h2:    sh_in = {sh_r[19:0], lnk.io[3:0]};
      default: sh_in = {sh_r[22:0], lnk.io[0]};
    endcase
    k        = sfr_pkg::sfr_kind(sh_in[7:0]);
    ph_nxt   = ph_e;
    pl_nxt   = pl_e;
    kd_nxt   = kd_e;
    cnt_nxt  = cnt_e - 5'h01;
    sh_nxt   = sh_in;
    addr_nxt = addr_r;
    cont_nxt = cont_r;
    case (ph_e)
      sfr_pkg::PH_CMD: begin
        if (cnt_e == 5'h01) begin
          pl_nxt  = sfr_pkg::sfr_plan(k);
          kd_nxt  = k;
          ph_nxt  = sfr_pkg::PH_ADDR;
          cnt_nxt = pl_nxt.ac;
          if (k == sfr_pkg::K_MRST) begin
            cont_nxt = sfr_pkg::K_NONE;
            ph_nxt   = sfr_pkg::PH_IDLE;
          end else if (k == sfr_pkg::K_NONE || busy_s) begin
            ph_nxt = sfr_pkg::PH_IDLE;
          end else if (pl_nxt.q && !qe_s) begin
            ph_nxt = sfr_pkg::PH_IDLE;
          end
        end
      end
      sfr_pkg::PH_ADDR: begin
        if (xip_nxt && cnt_e == pl_e.ac - 5'(pl_e.bc) + 5'h01
            && sh_in[7:0] == sfr_pkg::OP_MRST) begin
          cont_nxt = sfr_pkg::K_NONE;
          ph_nxt   = sfr_pkg::PH_IDLE;
        end else if (cnt_e == 5'h01) begin
          addr_nxt = sh_in;
          if (busy_s) begin
            ph_nxt = sfr_pkg::PH_IDLE;
          end else if (pl_e.mc != 4'h0) begin
            ph_nxt  = sfr_pkg::PH_MODE;
            cnt_nxt = 5'(pl_e.mc);
          end else if (pl_e.dm != 4'h0) begin
            ph_nxt  = sfr_pkg::PH_DUMMY;
            cnt_nxt = 5'(pl_e.dm);
          end else begin
            ph_nxt  = sfr_pkg::PH_DATA;
            cnt_nxt = 5'(pl_e.bc);
          end
        end
      end
      sfr_pkg::PH_MODE: begin
        if (cnt_e == 5'h01) begin
          // Mode bits decide whether the next frame carries an opcode
          if (sh_in[5:4] == sfr_pkg::MODE_KEEP) begin
            cont_nxt = kd_e;
          end else begin
            cont_nxt = sfr_pkg::K_NONE;
          end
          if (pl_e.dm != 4'h0) begin
            ph_nxt  = sfr_pkg::PH_DUMMY;
            cnt_nxt = 5'(pl_e.dm);
          end else begin
            ph_nxt  = sfr_pkg::PH_DATA;
            cnt_nxt = 5'(pl_e.bc);
          end
        end
      end
      sfr_pkg::PH_DUMMY: begin
        // Lane values are don't care here
        if (cnt_e == 5'h01) begin
          ph_nxt  = sfr_pkg::PH_DATA;
          cnt_nxt = 5'(pl_e.bc);
        end
      end
      sfr_pkg::PH_DATA: begin
        if (cnt_e == 5'h01) begin
          addr_nxt = addr_r + 24'h000001;
          cnt_nxt  = 5'(pl_e.bc);
        end
      end
      default: cnt_nxt = cnt_e;
    endcase
  end

  // Frame state dies with chip select
  always_ff @(posedge lnk.sclk or posedge lnk.cs_n) begin
    if (lnk.cs_n) begin
      ph_r  <= sfr_pkg::PH_CMD;
      pl_r  <= '0;
      kd_r  <= sfr_pkg::K_NONE;
      cnt_r <= 5'h00;
      sh_r  <= 24'h000000;
      fst_r <= 1'b1;
      xip_r <= 1'b0;
    end else begin
      ph_r  <= ph_nxt;
      pl_r  <= pl_nxt;
      kd_r  <= kd_nxt;
      cnt_r <= cnt_nxt;
      sh_r  <= sh_nxt;
      fst_r <= 1'b0;
      xip_r <= xip_nxt;
    end
  end

  // Continuous mode and address survive deselect
  always_ff @(posedge lnk.sclk or negedge nrst) begin
    if (!nrst) begin
      cont_r <= sfr_pkg::K_NONE;
      addr_r <= sfr_pkg::ADDR_RST;
    end else begin
      cont_r <= cont_nxt;
      addr_r <= addr_nxt;
    end
  end

  // ==========================================================
  // Falling edge: lane drive
  always_comb begin
    src      = (cnt_r == 5'(pl_r.bc)) ? mem_rdata : hold_r;
    o_nxt    = 4'h0;
    oe_nxt   = 4'h0;
    hold_nxt = hold_r;
    if (ph_r == sfr_pkg::PH_DATA) begin
      case (pl_r.dl)
        2'h1: begin
          o_nxt    = {2'h0, src[7:6]};
          oe_nxt   = 4'h3;
          hold_nxt = {src[5:0], 2'h0};
        end
        2'h2: begin
          o_nxt    = src[7:4];
          oe_nxt   = 4'hF;
          hold_nxt = {src[3:0], 4'h0};
        end
        default: begin
          o_nxt    = {2'h0, src[7], 1'b0};
          oe_nxt   = 4'h2;
          hold_nxt = {src[6:0], 1'b0};
        end
      endcase
    end
  end

  // Deselect releases the lanes at once
  always_ff @(negedge lnk.sclk or posedge lnk.cs_n) begin
    if (lnk.cs_n) begin
      o_r    <= 4'h0;
      oe_r   <= 4'h0;
      hold_r <= 8'h00;
    end else begin
      o_r    <= o_nxt;
      oe_r   <= oe_nxt;
      hold_r <= hold_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign lnk.d_o     = o_r;
  assign lnk.d_oe    = oe_r;
  assign mem_addr    = addr_r;
  assign cont_active = (cont_r != sfr_pkg::K_NONE);

endmodule

//--- rtl/sfr_host.sv
// Host side of the multi-lane read path: makes the link clock by a divider,
// sends command, address and mode, and collects data bytes.
// Assumes one request at a time from a user on clk_sys.
module sfr_host (
  // Link
  sfr_if.host                     lnk,
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               nrst,
  // Request
  input  wire logic               req_valid,
  output logic                    req_ready,
  input  wire sfr_pkg::sfr_kind_e req_kind,
  input  wire logic [23:0]        req_addr,
  input  wire logic [7:0]         req_mode,
  input  wire logic [7:0]         req_len,
  // Read data
  output logic [7:0]              rd_data,
  output logic                    rd_valid,
  output logic                    cont_active
);

  sfr_pkg::sfr_ph_e   ph_r, ph_nxt;
  sfr_pkg::sfr_plan_s pl_r, pl_nxt;
  sfr_pkg::sfr_kind_e kd_r, kd_nxt, cont_r, cont_nxt;
  logic [4:0]         cnt_r, cnt_nxt;
  logic [39:0]        tx_r, tx_nxt;
  logic [7:0]         rx_r, rx_nxt, len_r, len_nxt, rdd_r, rdd_nxt;
  logic [2:0]         div_r, div_nxt;
  logic [3:0]         o_r, o_nxt, oe_r, oe_nxt, io_s;
  logic               sclk_r, sclk_nxt, csn_r, csn_nxt, done_r, done_nxt, rdv_r, rdv_nxt;
  logic [1:0]         lw;

  sfr_sync #(
    .W (4)
  ) u_sync (
    .clk  (clk_sys),
    .nrst (nrst),
    .d    (lnk.io),
    .q    (io_s)
  );

  assign req_ready = (ph_r == sfr_pkg::PH_IDLE);

  always_comb begin
    ph_nxt   = ph_r;
    pl_nxt   = pl_r;
    kd_nxt   = kd_r;
    cont_nxt = cont_r;
    {cnt_nxt, tx_nxt} = {cnt_r, tx_r};
    {rx_nxt, len_nxt, rdd_nxt, o_nxt, oe_nxt} = {rx_r, len_r, rdd_r, o_r, oe_r};
    {sclk_nxt, csn_nxt, done_nxt} = {sclk_r, csn_r, done_r};
    rdv_nxt = 1'b0;
    div_nxt = (ph_r == sfr_pkg::PH_IDLE) ? 3'h0 : div_r + 3'h1;
    if (ph_r == sfr_pkg::PH_CMD && kd_r != sfr_pkg::K_MRST) begin
      lw = 2'h0;
    end else if (ph_r == sfr_pkg::PH_DATA) begin
      lw = pl_r.dl;
    end else begin
      lw = pl_r.al;
    end
    if (req_valid && req_ready) begin
      pl_nxt   = sfr_pkg::sfr_plan(req_kind);
      kd_nxt   = req_kind;
      csn_nxt  = 1'b0;
      done_nxt = 1'b0;
      len_nxt  = req_len;
      ph_nxt   = sfr_pkg::PH_CMD;
      cnt_nxt  = 5'(sfr_pkg::CMD_CLKS);
      tx_nxt   = {sfr_pkg::sfr_op(req_kind), req_addr, req_mode};
      o_nxt    = {3'h0, tx_nxt[39]};
      oe_nxt   = 4'h1;
      if (req_kind == sfr_pkg::K_MRST) begin
        cont_nxt = sfr_pkg::K_NONE;
        tx_nxt   = '1;
        o_nxt    = 4'hF;
        oe_nxt   = 4'hF;
      end else if (req_kind == cont_r) begin
        ph_nxt  = sfr_pkg::PH_ADDR;
        cnt_nxt = pl_nxt.ac;
        tx_nxt  = {req_addr, req_mode, 8'h00};
        o_nxt   = (pl_nxt.al == 2'h2) ? tx_nxt[39:36] : {2'h0, tx_nxt[39:38]};
        oe_nxt  = (pl_nxt.al == 2'h2) ? 4'hF : 4'h3;
      end
      if (pl_nxt.mc != 4'h0) begin
        cont_nxt = (req_mode[5:4] == sfr_pkg::MODE_KEEP) ? req_kind : sfr_pkg::K_NONE;
      end
    end else if (div_r == 3'(sfr_pkg::SCLK_HALF - 1)) begin
      div_nxt = 3'h0;
      if (!sclk_r) begin
        sclk_nxt = 1'b1;
        cnt_nxt  = cnt_r - 5'h01;
        case (lw)
          2'h1: begin
            tx_nxt = {tx_r[37:0], 2'h0};
            rx_nxt = {rx_r[5:0], io_s[1:0]};
          end
          2'h2: begin
            tx_nxt = {tx_r[35:0], 4'h0};
            rx_nxt = {rx_r[3:0], io_s};
          end
          default: begin
            tx_nxt = {tx_r[38:0], 1'b0};
            rx_nxt = {rx_r[6:0], io_s[1]};
          end
        endcase
        if (cnt_r == 5'h01) begin
          case (ph_r)
            sfr_pkg::PH_CMD: begin
              done_nxt = (kd_r == sfr_pkg::K_MRST);
              ph_nxt   = sfr_pkg::PH_ADDR;
              cnt_nxt  = pl_r.ac;
            end
            sfr_pkg::PH_ADDR, sfr_pkg::PH_MODE: begin
              if (ph_r == sfr_pkg::PH_ADDR && pl_r.mc != 4'h0) begin
                ph_nxt  = sfr_pkg::PH_MODE;
                cnt_nxt = 5'(pl_r.mc);
              end else if (pl_r.dm != 4'h0) begin
                ph_nxt  = sfr_pkg::PH_DUMMY;
                cnt_nxt = 5'(pl_r.dm);
              end else begin
                ph_nxt  = sfr_pkg::PH_DATA;
                cnt_nxt = 5'(pl_r.bc);
              end
            end
            sfr_pkg::PH_DUMMY: begin
              ph_nxt  = sfr_pkg::PH_DATA;
              cnt_nxt = 5'(pl_r.bc);
            end
            default: begin
              rdv_nxt  = 1'b1;
              rdd_nxt  = rx_nxt;
              len_nxt  = len_r - 8'h01;
              cnt_nxt  = 5'(pl_r.bc);
              done_nxt = (len_r == 8'h01);
            end
          endcase
        end
      end else begin
        sclk_nxt = 1'b0;
        o_nxt    = 4'h0;
        oe_nxt   = 4'h0;
        if (done_r) begin
          ph_nxt  = sfr_pkg::PH_IDLE;
          csn_nxt = 1'b1;
        end else if (ph_r == sfr_pkg::PH_CMD || ph_r == sfr_pkg::PH_ADDR || ph_r == sfr_pkg::PH_MODE) begin
          case (lw)
            2'h1: begin
              o_nxt  = {2'h0, tx_r[39:38]};
              oe_nxt = 4'h3;
            end
            2'h2: begin
              o_nxt  = tx_r[39:36];
              oe_nxt = 4'hF;
            end
            default: begin
              o_nxt  = {3'h0, tx_r[39]};
              oe_nxt = 4'h1;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ph_r   <= sfr_pkg::PH_IDLE;
      pl_r   <= '0;
      kd_r   <= sfr_pkg::K_NONE;
      cont_r <= sfr_pkg::K_NONE;
      {cnt_r, tx_r, rx_r, len_r, rdd_r, div_r} <= '0;
      {o_r, oe_r, sclk_r, csn_r, done_r, rdv_r} <= 12'h004;
    end else begin
      ph_r   <= ph_nxt;
      pl_r   <= pl_nxt;
      kd_r   <= kd_nxt;
      cont_r <= cont_nxt;
      {cnt_r, tx_r, rx_r, len_r, rdd_r, div_r} <= {cnt_nxt, tx_nxt, rx_nxt, len_nxt, rdd_nxt, div_nxt};
      {o_r, oe_r, sclk_r, csn_r, done_r, rdv_r} <= {o_nxt, oe_nxt, sclk_nxt, csn_nxt, done_nxt, rdv_nxt};
    end
  end

  assign lnk.sclk    = sclk_r;
  assign lnk.cs_n    = csn_r;
  assign lnk.h_o     = o_r;
  assign lnk.h_oe    = oe_r;
  assign rd_data     = rdd_r;
  assign rd_valid    = rdv_r;
  assign cont_active = (cont_r != sfr_pkg::K_NONE);

endmodule

//--- dv/sfr_chk.sv
// Link checker for the multi-lane flash read path, sampled on the system clock.
// Assumes it watches the interface that joins the host and device ends.
module sfr_chk (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       nrst,
  // Link
  input wire logic       sclk,
  input wire logic       cs_n,
  input wire logic [3:0] h_o,
  input wire logic [3:0] h_oe,
  input wire logic [3:0] d_o,
  input wire logic [3:0] d_oe,
  input wire logic [3:0] io
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Rising link edges since frame start
  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;
  logic       sclk_r;
  logic       sclk_nxt;
  always_comb begin
    sclk_nxt = sclk;
    cnt_nxt  = cnt_r;
    if (cs_n) begin
      cnt_nxt = 7'h00;
    end else if (sclk && !sclk_r && cnt_r != 7'h7F) begin
      cnt_nxt = cnt_r + 7'h01;
    end
  end
  always_ff @(posedge clk_sys) begin
    sclk_r <= sclk_nxt;
    cnt_r  <= cnt_nxt;
  end
  // ==========================================================
  // Assertions
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_fast_start;
    !cs_n && $rose(d_oe == 4'h2);
  endsequence
  sequence s_sample;
    !cs_n && $rose(sclk);
  endsequence
  chk_cs_release: assert property (cs_n |-> d_oe == 4'h0)
    else $error("device drives a lane while deselected");
  chk_doe_fall: assert property (!cs_n && !$past(cs_n) && $changed(d_oe) |-> $fell(sclk))
    else $error("device lane enable changed off a falling edge");
  chk_no_contention: assert property ((d_oe & h_oe) == 4'h0)
    else $error("host and device drive one lane");
  chk_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("link clock high while deselected");
  chk_host_stable: assert property (!cs_n && !$past(cs_n) && $changed(h_o & h_oe) |-> $fell(sclk))
    else $error("host lane changed off a falling edge");
  chk_early_quiet: assert property (!cs_n && cnt_r < 7'h08 |-> d_oe == 4'h0)
    else $error("device drives during first eight clocks");
  chk_lane_set: assert property (d_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
    else $error("device lane enable pattern illegal");
  chk_fast_start: assert property (s_fast_start |-> cnt_r == 7'h28)
    else $error("single lane data not after forty clocks");
  chk_io_hold: assert property (s_sample |-> ($stable(io) && $stable(d_o & d_oe)) [*3])
    else $error("lane moved while sampled high");
endmodule

//--- dv/tb_serial_flash_multi_io_read.sv
// Testbench: host and device ends joined by the link, array modelled by a hash.
// Assumes the host's user port and the status levels are the only stimulus.
module tb_serial_flash_multi_io_read;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Signals
  logic               clk_sys = 1'b0;
  logic               nrst;
  logic               req_valid;
  sfr_pkg::sfr_kind_e req_kind;
  logic [23:0]        req_addr;
  logic [7:0]         req_mode;
  logic [7:0]         req_len;
  logic               quad_lane_enable;
  logic               write_busy_flag;
  logic               req_ready;
  logic               rd_valid;
  logic               h_cont;
  logic               d_cont;
  logic [7:0]         rd_data;
  logic [7:0]         mem_rdata;
  logic [23:0]        mem_addr;
  logic [7:0]         exp_q[$];
  int                 failures = 0;
  int                 n_tests = 0;
  sfr_pkg::sfr_kind_e kinds[5] = '{sfr_pkg::K_FAST, sfr_pkg::K_DOUT, sfr_pkg::K_DIO,
                                   sfr_pkg::K_QOUT, sfr_pkg::K_QIO};

  always #5 clk_sys = ~clk_sys;

  function automatic logic [7:0] mem_val(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3C;
  endfunction
  assign mem_rdata = mem_val(mem_addr);

  // ==========================================================
  // Design
  sfr_if sfr_if_i ();
  sfr_host sfr_host_i (.lnk(sfr_if_i), .clk_sys(clk_sys), .nrst(nrst), .req_valid(req_valid),
    .req_ready(req_ready), .req_kind(req_kind), .req_addr(req_addr), .req_mode(req_mode),
    .req_len(req_len), .rd_data(rd_data), .rd_valid(rd_valid), .cont_active(h_cont));
  sfr_dev sfr_dev_i (.lnk(sfr_if_i), .nrst(nrst), .quad_lane_enable(quad_lane_enable),
    .write_busy_flag(write_busy_flag), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .cont_active(d_cont));
  sfr_chk sfr_chk_i (.clk_sys(clk_sys), .nrst(nrst), .sclk(sfr_if_i.sclk), .cs_n(sfr_if_i.cs_n),
    .h_o(sfr_if_i.h_o), .h_oe(sfr_if_i.h_oe), .d_o(sfr_if_i.d_o), .d_oe(sfr_if_i.d_oe),
    .io(sfr_if_i.io));

  // ==========================================================
  // Compare and report
  task automatic cmp8(input string what, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic cmp1(input string what, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic flags(input logic e);
    cmp1("host cont", e, h_cont);
    cmp1("dev cont", e, d_cont);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Byte monitor
  always @(posedge clk_sys) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        cmp8("stray byte", 8'h00, 8'hXX);
      end else begin
        cmp8("read byte", exp_q.pop_front(), rd_data);
      end
    end
  end

  // ==========================================================
  // Driver: one request, expected bytes queued, bounded wait for the end
  task automatic run(input sfr_pkg::sfr_kind_e k, input logic [23:0] a, input logic [7:0] m,
                     input int n, input logic ok);
    int i;
    for (i = 0; i < n; i++) begin
      exp_q.push_back(ok ? mem_val(a + 24'(i)) : 8'hFF);
    end
    req_kind  <= k;
    req_addr  <= a;
    req_mode  <= m;
    req_len   <= 8'(n);
    req_valid <= 1'b1;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    for (i = 0; i < 20000; i++) begin
      @(posedge clk_sys);
      #1;
      if (req_ready === 1'b1 && exp_q.size() == 0) break;
    end
    if (i == 20000) begin
      failures++;
      $display("[ERR] request end expected done seen timeout");
      results();
    end
    @(posedge clk_sys);
    $display("test kind %0d addr %h done", k, a);
  endtask

  // ==========================================================
  // Tests
  initial begin
    nrst = 1'b0;
    req_valid = 1'b0;
    req_kind = sfr_pkg::K_NONE;
    req_addr = 24'h000000;
    req_mode = 8'h00;
    req_len = 8'h00;
    quad_lane_enable = 1'b1;
    write_busy_flag = 1'b0;
    void'($urandom(32'h70d2));
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    run(sfr_pkg::K_FAST, 24'hFFFFFE, 8'h00, 3, 1'b1);
    run(sfr_pkg::K_QIO, 24'hFFFFFF, 8'h00, 2, 1'b1);
    foreach (kinds[j]) begin
      run(kinds[j], 24'($urandom), 8'($urandom) & 8'hCF, 2, 1'b1);
    end
    run(sfr_pkg::K_DIO, 24'($urandom), 8'h20, 2, 1'b1);
    flags(1'b1);
    run(sfr_pkg::K_DIO, 24'($urandom) & 24'h7FFFFF, 8'h10, 2, 1'b1);
    flags(1'b0);
    run(sfr_pkg::K_QIO, 24'($urandom), 8'hA5, 2, 1'b1);
    flags(1'b1);
    run(sfr_pkg::K_QIO, 24'($urandom) & 24'h7FFFFF, 8'hE7, 3, 1'b1);
    flags(1'b1);
    run(sfr_pkg::K_MRST, 24'h000000, 8'h00, 0, 1'b1);
    flags(1'b0);
    write_busy_flag <= 1'b1;
    run(sfr_pkg::K_FAST, 24'($urandom), 8'h00, 2, 1'b0);
    run(sfr_pkg::K_QIO, 24'($urandom), 8'h00, 2, 1'b0);
    write_busy_flag <= 1'b0;
    run(sfr_pkg::K_DOUT, 24'($urandom), 8'h00, 2, 1'b1);
    quad_lane_enable <= 1'b0;
    run(sfr_pkg::K_QOUT, 24'($urandom), 8'h00, 2, 1'b0);
    run(sfr_pkg::K_QIO, 24'($urandom), 8'h00, 2, 1'b0);
    quad_lane_enable <= 1'b1;
    run(sfr_pkg::K_QOUT, 24'($urandom), 8'h00, 2, 1'b1);
    results();
  end
endmodule
